// ### src/pbc_pkg.sv
/*
 * pbc_pkg: constants of the basic control register block.
 * assumes: a single 200 MHz clock domain.
 */
package pbc_pkg;
    // -------------------------------------------------------------
    // register map
    // -------------------------------------------------------------
    localparam logic [4:0] PBC_BASIC_CONTROL_ADDR = 5'h00;
    localparam int PBC_RESET_BIT = 15;
    localparam int PBC_LOOPBACK_BIT = 14;
    localparam int PBC_RATE_BIT = 13;
    localparam int PBC_AUTONEG_BIT = 12;
    localparam int PBC_LOW_POWER_BIT = 11;
    localparam int PBC_ISOLATE_BIT = 10;
    localparam int PBC_RESTART_BIT = 9;
    localparam int PBC_DUPLEX_BIT = 8;
    localparam int PBC_COLTEST_BIT = 7;
    localparam logic [15:0] PBC_WRITABLE_MASK = 16'hff80;
    // reset value without isolate; isolate follows the strapped address
    localparam logic [15:0] PBC_CONTROL_RESET = 16'h3000;
    localparam logic [4:0] PBC_ZERO_ADDR = 5'h00;
    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int PBC_CLK_MHZ = 200;
    localparam int PBC_SOFT_RESET_NS = 1000;
    localparam int PBC_SOFT_RESET_CYCLES =
        (PBC_SOFT_RESET_NS * PBC_CLK_MHZ + 999) / 1000;
    // loopback latency: fewer than 512 bit times; 10 ns per bit at 100M
    localparam int PBC_LOOP_LIMIT_BITS = 512;
    localparam int PBC_LOOP_STAGES = 2;
    localparam int PBC_CNT_W = 16;
endpackage : pbc_pkg

// ### src/pbc_loopback.sv
/*
 * pbc_loopback: registered mii transmit-to-receive loop path.
 * assumes: mii nibble signals synchronous to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module pbc_loopback
    import pbc_pkg::*;
#(
    parameter int STAGES = PBC_LOOP_STAGES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic [3:0] tx_data,
    input wire logic tx_en,
    input wire logic tx_er,
    output logic [3:0] rx_data,
    output logic rx_dv,
    output logic rx_er
);
    logic [5:0] pipe_reg [STAGES];

    // a fixed short pipe keeps rx_dv far inside the 512 bit-time bound
    genvar i;
    generate
        for (i = 0; i < STAGES; i++) begin : g_stage
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    pipe_reg[i] <= 6'h00;
                end else if (flush) begin
                    pipe_reg[i] <= 6'h00;
                end else if (i == 0) begin
                    pipe_reg[i] <= {tx_en, tx_er, tx_data};
                end else begin
                    pipe_reg[i] <= pipe_reg[(i == 0) ? 0 : i - 1];
                end
            end
        end
    endgenerate

    assign rx_dv = pipe_reg[STAGES-1][5];
    assign rx_er = pipe_reg[STAGES-1][4];
    assign rx_data = pipe_reg[STAGES-1][3:0];
endmodule // pbc_loopback
`default_nettype wire

// ### src/pbc_basic_control.sv
/*
 * pbc_basic_control: basic control register of a 10/100 phy and the
 * mode decode it drives (rate, duplex, negotiation, loopback, isolate,
 * low power, soft reset).
 * assumes: management frames already decoded into a one-cycle read or
 * write strobe with 5-bit register address; mii pins synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module pbc_basic_control
    import pbc_pkg::*;
#(
    parameter int SOFT_RESET_CYCLES = PBC_SOFT_RESET_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    // management access
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [4:0] mgmt_addr,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_busy,
    // straps and mode pins
    input wire logic [4:0] phy_address_strap,
    input wire logic hardware_software_select_pin,
    input wire logic rate_select_pin,
    input wire logic negotiation_select_pin,
    input wire logic duplex_select_pin,
    // negotiation engine
    input wire logic neg_done,
    input wire logic neg_speed_100,
    input wire logic neg_full_duplex,
    output logic neg_enable,
    output logic neg_restart,
    // latching status bits held elsewhere
    output logic latch_status_clear,
    output logic soft_reset_active,
    // resolved mode
    output logic speed_100,
    output logic full_duplex,
    // mac side
    input wire logic [3:0] mac_tx_data,
    input wire logic mac_tx_en,
    input wire logic mac_tx_er,
    input wire logic [3:0] line_rx_data,
    input wire logic line_rx_dv,
    input wire logic line_rx_er,
    input wire logic line_crs,
    input wire logic line_col,
    output logic [3:0] mac_rx_data,
    output logic mac_rx_dv,
    output logic mac_rx_er,
    output logic mac_crs,
    output logic mac_col,
    output logic mac_out_oe,
    // line side
    output logic [3:0] line_tx_data,
    output logic line_tx_en,
    output logic line_tx_er,
    output logic pair_transmit_tristate,
    output logic pair_rx_enable,
    output logic col_detect_enable
);
    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        PBC_RUN = 2'b00,
        PBC_SRST = 2'b01,
        PBC_STRAP = 2'b10
    } pbc_state_e;

    pbc_state_e state_reg;
    logic [PBC_CNT_W-1:0] rst_cnt_reg;
    logic loopback_reg;
    logic rate_reg;
    logic autoneg_reg;
    logic low_power_reg;
    logic isolate_reg;
    logic restart_reg;
    logic duplex_reg;
    logic coltest_reg;
    logic low_power_q_reg;
    logic restart_issued_reg;
    logic [15:0] rdata_reg;
    logic access_ok;
    logic wr_ctrl;
    logic strap_isolate;
    logic neg_on;
    logic loop_rx_dv;
    logic loop_rx_er;
    logic [3:0] loop_rx_data;
    logic mac_in_ok;

    assign strap_isolate = (phy_address_strap == PBC_ZERO_ADDR);
    // management writes blocked outside run (soft reset, strap); reads still return the word
    assign access_ok = (state_reg == PBC_RUN);
    assign wr_ctrl = mgmt_wr && access_ok &&
                     (mgmt_addr == PBC_BASIC_CONTROL_ADDR);
    assign mgmt_busy = !access_ok;
    assign soft_reset_active = (state_reg != PBC_RUN);

    // -------------------------------------------------------------
    // soft reset sequencer
    // -------------------------------------------------------------
    // strap is caught by a clock edge after release, never in reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= PBC_STRAP;
            rst_cnt_reg <= '0;
        end else begin
            case (state_reg)
                PBC_RUN: begin
                    if (wr_ctrl && mgmt_wdata[PBC_RESET_BIT]) begin
                        state_reg <= PBC_SRST;
                        rst_cnt_reg <= '0;
                    end
                end
                PBC_SRST: begin
                    if (rst_cnt_reg ==
                        PBC_CNT_W'(SOFT_RESET_CYCLES - 1)) begin
                        state_reg <= PBC_STRAP;
                    end else begin
                        rst_cnt_reg <= rst_cnt_reg + 1'b1;
                    end
                end
                PBC_STRAP: begin
                    state_reg <= PBC_RUN;
                end
                default: begin
                    state_reg <= PBC_STRAP;
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // control bits
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            loopback_reg <= 1'b0;
            rate_reg <= PBC_CONTROL_RESET[PBC_RATE_BIT];
            autoneg_reg <= PBC_CONTROL_RESET[PBC_AUTONEG_BIT];
            low_power_reg <= 1'b0;
            isolate_reg <= 1'b0;
            duplex_reg <= 1'b0;
            coltest_reg <= 1'b0;
        end else if (state_reg != PBC_RUN) begin
            // defaults held through soft reset, isolate from strap
            loopback_reg <= PBC_CONTROL_RESET[PBC_LOOPBACK_BIT];
            rate_reg <= PBC_CONTROL_RESET[PBC_RATE_BIT];
            autoneg_reg <= PBC_CONTROL_RESET[PBC_AUTONEG_BIT];
            low_power_reg <= PBC_CONTROL_RESET[PBC_LOW_POWER_BIT];
            isolate_reg <= strap_isolate;
            duplex_reg <= PBC_CONTROL_RESET[PBC_DUPLEX_BIT];
            coltest_reg <= PBC_CONTROL_RESET[PBC_COLTEST_BIT];
        end else if (wr_ctrl && !mgmt_wdata[PBC_RESET_BIT]) begin
            loopback_reg <= mgmt_wdata[PBC_LOOPBACK_BIT];
            rate_reg <= mgmt_wdata[PBC_RATE_BIT];
            autoneg_reg <= mgmt_wdata[PBC_AUTONEG_BIT];
            low_power_reg <= mgmt_wdata[PBC_LOW_POWER_BIT];
            isolate_reg <= mgmt_wdata[PBC_ISOLATE_BIT];
            duplex_reg <= mgmt_wdata[PBC_DUPLEX_BIT];
            coltest_reg <= mgmt_wdata[PBC_COLTEST_BIT];
        end
    end

    // restart is self-clearing once negotiation has been kicked
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            restart_reg <= 1'b0;
            restart_issued_reg <= 1'b0;
        end else if (state_reg != PBC_RUN) begin
            restart_reg <= 1'b0;
            restart_issued_reg <= 1'b0;
        end else if (wr_ctrl && !mgmt_wdata[PBC_RESET_BIT] &&
                     mgmt_wdata[PBC_RESTART_BIT] && neg_on &&
                     mgmt_wdata[PBC_AUTONEG_BIT]) begin
            restart_reg <= 1'b1;
            restart_issued_reg <= 1'b0;
        end else if (restart_reg && !restart_issued_reg) begin
            restart_issued_reg <= 1'b1;
        end else if (restart_reg) begin
            restart_reg <= 1'b0;
            restart_issued_reg <= 1'b0;
        end
    end

    assign neg_restart = restart_reg && !restart_issued_reg;

    // entering low power through the bit, and every cycle outside run (soft reset, strap), clear latched status
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_power_q_reg <= 1'b0;
        end else begin
            low_power_q_reg <= low_power_reg;
        end
    end

    assign latch_status_clear = (low_power_reg && !low_power_q_reg) ||
                                (state_reg != PBC_RUN);

    // -------------------------------------------------------------
    // read path
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 16'h0000;
        end else if (mgmt_rd && mgmt_addr == PBC_BASIC_CONTROL_ADDR) begin
            rdata_reg <= '0;
            rdata_reg[PBC_RESET_BIT] <= !access_ok;
            rdata_reg[PBC_LOOPBACK_BIT] <= loopback_reg;
            rdata_reg[PBC_RATE_BIT] <= rate_reg;
            rdata_reg[PBC_AUTONEG_BIT] <= autoneg_reg;
            rdata_reg[PBC_LOW_POWER_BIT] <= low_power_reg;
            rdata_reg[PBC_ISOLATE_BIT] <= isolate_reg;
            rdata_reg[PBC_RESTART_BIT] <= restart_reg;
            rdata_reg[PBC_DUPLEX_BIT] <= duplex_reg;
            rdata_reg[PBC_COLTEST_BIT] <= coltest_reg;
        end else if (mgmt_rd) begin
            rdata_reg <= 16'h0000;
        end
    end

    assign mgmt_rdata = rdata_reg;

    // -------------------------------------------------------------
    // mode resolution
    // -------------------------------------------------------------
    // pins rule in hardware mode; bits undefined then
    assign neg_on = hardware_software_select_pin ? autoneg_reg
                                                 : negotiation_select_pin;
    assign neg_enable = neg_on && access_ok && !low_power_reg;

    always_comb begin
        if (!hardware_software_select_pin) begin
            speed_100 = rate_select_pin;
            full_duplex = duplex_select_pin;
        end else if (autoneg_reg) begin
            speed_100 = neg_done ? neg_speed_100 : rate_reg;
            full_duplex = neg_done && neg_full_duplex;
        end else begin
            speed_100 = rate_reg;
            // duplex bit ignored in loopback
            full_duplex = duplex_reg && !loopback_reg;
        end
    end

    // -------------------------------------------------------------
    // data paths
    // -------------------------------------------------------------
    // same path for any mac interface option: no config input here
    assign mac_in_ok = !isolate_reg && !low_power_reg &&
                       access_ok;

    pbc_loopback #(
        .STAGES(PBC_LOOP_STAGES)
    ) u_loop (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .flush(!loopback_reg || !mac_in_ok),
        .tx_data(mac_tx_data),
        .tx_en(mac_tx_en),
        .tx_er(mac_tx_er),
        .rx_data(loop_rx_data),
        .rx_dv(loop_rx_dv),
        .rx_er(loop_rx_er)
    );

    assign pair_transmit_tristate = low_power_reg || loopback_reg ||
                                    !access_ok;
    assign pair_rx_enable = !loopback_reg && !low_power_reg;
    assign col_detect_enable = !low_power_reg &&
                               (!loopback_reg || coltest_reg);

    // line transmit only when pair is live
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_tx_data <= 4'h0;
            line_tx_en <= 1'b0;
            line_tx_er <= 1'b0;
        end else if (mac_in_ok && !loopback_reg) begin
            line_tx_data <= mac_tx_data;
            line_tx_en <= mac_tx_en;
            line_tx_er <= mac_tx_er;
        end else begin
            line_tx_data <= 4'h0;
            line_tx_en <= 1'b0;
            line_tx_er <= 1'b0;
        end
    end

    // mac receive outputs, forced low in low power
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mac_rx_data <= 4'h0;
            mac_rx_dv <= 1'b0;
            mac_rx_er <= 1'b0;
            mac_crs <= 1'b0;
            mac_col <= 1'b0;
        end else if (low_power_reg || !access_ok) begin
            mac_rx_data <= 4'h0;
            mac_rx_dv <= 1'b0;
            mac_rx_er <= 1'b0;
            mac_crs <= 1'b0;
            mac_col <= 1'b0;
        end else if (loopback_reg) begin
            mac_rx_data <= loop_rx_data;
            mac_rx_dv <= loop_rx_dv;
            mac_rx_er <= loop_rx_er;
            mac_crs <= mac_tx_en && mac_in_ok;
            mac_col <= coltest_reg && mac_tx_en && mac_in_ok;
        end else begin
            mac_rx_data <= line_rx_data;
            mac_rx_dv <= line_rx_dv;
            mac_rx_er <= line_rx_er;
            mac_crs <= line_crs;
            mac_col <= line_col && col_detect_enable;
        end
    end

    // isolate floats mac outputs; low power drives them low instead
    assign mac_out_oe = !isolate_reg || low_power_reg;
endmodule // pbc_basic_control
`default_nettype wire

// ### sim/pbc_basic_control_asserts.sv
/* pbc_basic_control_asserts: port-level checks of the control register.
   assumes: bound to pbc_basic_control; single sys_clk domain. */
`timescale 1ns/1ps
`default_nettype none
module pbc_basic_control_asserts
    import pbc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic mgmt_wr,
    input wire logic [4:0] mgmt_addr,
    input wire logic [15:0] mgmt_wdata,
    input wire logic mgmt_busy,
    input wire logic [4:0] phy_address_strap,
    input wire logic hardware_software_select_pin,
    input wire logic rate_select_pin,
    input wire logic negotiation_select_pin,
    input wire logic duplex_select_pin,
    input wire logic neg_enable,
    input wire logic neg_restart,
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic mac_tx_en,
    input wire logic mac_rx_dv,
    input wire logic mac_crs,
    input wire logic mac_col,
    input wire logic mac_out_oe,
    input wire logic pair_transmit_tristate
);
    // ------------------------------------------------------------
    // shadow of the control word
    // ------------------------------------------------------------
    logic [15:0] ctl_reg;
    logic take;
    logic hws;
    assign take = mgmt_wr && !mgmt_busy && mgmt_addr == 5'h00;
    assign hws = hardware_software_select_pin;
    // isolate default follows the strap while the block is busy
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_reg <= PBC_CONTROL_RESET;
        end else if (mgmt_busy) begin
            ctl_reg <= PBC_CONTROL_RESET;
            ctl_reg[10] <= (phy_address_strap == 5'h00);
        end else if (take && !mgmt_wdata[15]) begin
            ctl_reg <= mgmt_wdata & PBC_WRITABLE_MASK;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    soft_reset_a: assert property (
        take && mgmt_wdata[15] |=> mgmt_busy [*2])
        else $error("soft reset not entered");
    rate_pin_a: assert property (
        !hws && !negotiation_select_pin && !mgmt_busy
        |-> speed_100 == rate_select_pin) else $error("rate pin ignored");
    neg_pin_a: assert property (
        !hws && !ctl_reg[11] && !mgmt_busy
        |-> neg_enable == negotiation_select_pin)
        else $error("negotiation pin ignored");
    duplex_pin_a: assert property (
        !hws && !negotiation_select_pin && !mgmt_busy
        |-> full_duplex == duplex_select_pin) else $error("duplex pin");
    soft_mode_a: assert property (
        hws && ctl_reg[14:11] == 4'h0 && $stable(ctl_reg) && !mgmt_busy
        |-> speed_100 == ctl_reg[13] && full_duplex == ctl_reg[8])
        else $error("mode does not follow bits");
    restart_off_a: assert property (
        take && hws && !mgmt_wdata[15] && !mgmt_wdata[12]
        |=> !neg_restart [*2]) else $error("restart not ignored");
    restart_on_a: assert property (
        take && hws && ctl_reg[12] && mgmt_wdata[15:12] == 4'h1 &&
        mgmt_wdata[9] |-> ##[1:2] neg_restart) else $error("restart missing");
    loop_dv_a: assert property (
        ctl_reg[14] && ctl_reg[11:10] == 2'b00 && $rose(mac_tx_en)
        |-> ##[1:4] mac_rx_dv) else $error("loopback too slow");
    isolate_oe_a: assert property (
        ctl_reg[11:10] == 2'b01 && $stable(ctl_reg) && !mgmt_busy
        |-> !mac_out_oe) else $error("isolate left outputs on");
    low_power_a: assert property (
        ctl_reg[11] && $stable(ctl_reg) && !mgmt_busy
        |-> pair_transmit_tristate && !mac_rx_dv && !mac_crs && !mac_col)
        else $error("low power outputs wrong");
endmodule // pbc_basic_control_asserts
`default_nettype wire

// ### sim/pbc_station.sv
/* pbc_station: management station model issuing register strobes.
   assumes: strobes sampled at posedge sys_clk, read data a cycle later. */
`timescale 1ns/1ps
`default_nettype none
module pbc_station
    import pbc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic mgmt_busy,
    input wire logic [15:0] mgmt_rdata,
    output logic mgmt_wr,
    output logic mgmt_rd,
    output logic [4:0] mgmt_addr,
    output logic [15:0] mgmt_wdata
);
    initial begin
        mgmt_wr = 1'b0;
        mgmt_rd = 1'b0;
        mgmt_addr = 5'h00;
        mgmt_wdata = 16'h0000;
    end
    // busy drops write strobes, so never issue one into it
    task automatic wait_idle();
        int n;
        n = 0;
        @(posedge sys_clk);
        while (mgmt_busy !== 1'b0 && n < 1000) begin
            n++;
            @(posedge sys_clk);
        end
    endtask
    task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
        wait_idle();
        mgmt_addr <= a;
        mgmt_wdata <= d & PBC_WRITABLE_MASK;
        mgmt_wr <= 1'b1;
        @(posedge sys_clk);
        mgmt_wr <= 1'b0;
    endtask
    task automatic read_reg(input logic [4:0] a, output logic [15:0] d);
        wait_idle();
        mgmt_addr <= a;
        mgmt_rd <= 1'b1;
        @(posedge sys_clk);
        mgmt_rd <= 1'b0;
        @(posedge sys_clk);
        d = mgmt_rdata;
    endtask
endmodule // pbc_station
`default_nettype wire

// ### sim/pbc_basic_control_test.sv
/* pbc_basic_control_test: self-checking bench of the control register.
   assumes: the design, pbc_station and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module pbc_basic_control_test;
    localparam int SR_CYC = 4;
    logic sys_clk = 1'b0;
    logic rst_n, mgmt_wr, mgmt_rd, mgmt_busy, neg_enable, neg_restart;
    logic [4:0] mgmt_addr, phy_address_strap;
    logic [15:0] mgmt_wdata, mgmt_rdata, rd_word;
    logic hardware_software_select_pin, rate_select_pin;
    logic negotiation_select_pin, duplex_select_pin;
    logic neg_done, neg_speed_100, neg_full_duplex;
    logic latch_status_clear, soft_reset_active, speed_100, full_duplex;
    logic [3:0] mac_tx_data, mac_rx_data, line_tx_data;
    logic mac_tx_en, mac_tx_er, mac_rx_dv, mac_rx_er, mac_crs, mac_col;
    logic mac_out_oe, line_tx_en, line_tx_er, pair_transmit_tristate;
    logic pair_rx_enable, col_detect_enable;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_restart = 0;
    int n_clear = 0;
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (neg_restart === 1'b1) n_restart++;
        if (latch_status_clear === 1'b1) n_clear++;
    end
    pbc_station st (.sys_clk, .mgmt_busy, .mgmt_rdata, .mgmt_wr, .mgmt_rd,
        .mgmt_addr, .mgmt_wdata);
    // line receive side held quiet: only loopback traffic is checked
    pbc_basic_control #(.SOFT_RESET_CYCLES(SR_CYC)) dut (
        .sys_clk, .rst_n, .mgmt_wr, .mgmt_rd, .mgmt_addr, .mgmt_wdata,
        .mgmt_rdata, .mgmt_busy, .phy_address_strap,
        .hardware_software_select_pin, .rate_select_pin,
        .negotiation_select_pin, .duplex_select_pin, .neg_done,
        .neg_speed_100, .neg_full_duplex, .neg_enable, .neg_restart,
        .latch_status_clear, .soft_reset_active, .speed_100, .full_duplex,
        .mac_tx_data, .mac_tx_en, .mac_tx_er, .line_rx_data(4'h0),
        .line_rx_dv(1'b0), .line_rx_er(1'b0), .line_crs(1'b0),
        .line_col(1'b0), .mac_rx_data, .mac_rx_dv, .mac_rx_er, .mac_crs,
        .mac_col, .mac_out_oe, .line_tx_data, .line_tx_en, .line_tx_er,
        .pair_transmit_tristate, .pair_rx_enable, .col_detect_enable);
    // ------------------------------------------------------------
    // compare and closing tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [4:0] a, input logic [15:0] exp);
        st.read_reg(a, rd_word);
        chk(rd_word, exp);
    endtask
    task automatic settle();
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // whole sequence needs a few hundred cycles; 40000 is ample
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        int n;
        rst_n = 1'b0;
        phy_address_strap = 5'h01;
        hardware_software_select_pin = 1'b1;
        {rate_select_pin, negotiation_select_pin, duplex_select_pin} = 3'h0;
        {neg_done, neg_speed_100, neg_full_duplex} = 3'h0;
        {mac_tx_data, mac_tx_en, mac_tx_er} = 6'h00;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        chk_reg(5'h00, 16'h3000);
        chk_reg(5'h01, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            st.write_reg(5'h00, {2'b00, i[1], 4'h0, i[0], 8'h7f});
            settle();
            chk({15'h0, speed_100}, {15'h0, i[1]});
            chk({15'h0, full_duplex}, {15'h0, i[0]});
        end
        st.write_reg(5'h00, 16'h1000);
        {neg_done, neg_speed_100, neg_full_duplex} <= 3'h7;
        settle();
        chk({14'h0, speed_100, full_duplex}, 16'h3);
        neg_done <= 1'b0;
        n = n_restart;
        st.write_reg(5'h00, 16'h1200);
        settle();
        chk(16'(n_restart - n), 16'h1);
        chk_reg(5'h00, 16'h1000);
        n = n_restart;
        st.write_reg(5'h00, 16'h0200);
        settle();
        chk(16'(n_restart - n), 16'h0);
        chk_reg(5'h00, 16'h0000);
        hardware_software_select_pin <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            {rate_select_pin, negotiation_select_pin,
             duplex_select_pin} <= 3'(i);
            settle();
            chk({15'h0, neg_enable}, {15'h0, i[1]});
            if (i[1] == 1'b0) begin
                chk({15'h0, speed_100}, {15'h0, i[2]});
                chk({15'h0, full_duplex}, {15'h0, i[0]});
            end
        end
        hardware_software_select_pin <= 1'b1;
        st.write_reg(5'h00, 16'h6100);
        settle();
        chk({14'h0, pair_rx_enable, col_detect_enable}, 16'h0);
        chk({15'h0, full_duplex}, 16'h0);
        {mac_tx_data, mac_tx_en} <= 5'h15;
        n = 0;
        @(posedge sys_clk);
        while (mac_rx_dv !== 1'b1 && n < 1024) begin
            n++;
            @(posedge sys_clk);
        end
        chk({12'h0, mac_rx_data}, 16'h000a);
        chk({15'h0, n < 1024}, 16'h1);
        chk({14'h0, mac_crs, mac_col}, 16'h2);
        st.write_reg(5'h00, 16'h6180);
        settle();
        chk({15'h0, col_detect_enable}, 16'h1);
        chk({14'h0, mac_col, line_tx_en}, 16'h2);
        st.write_reg(5'h00, 16'h2400);
        settle();
        chk({14'h0, mac_out_oe, line_tx_en}, 16'h0);
        chk_reg(5'h00, 16'h2400);
        n = n_clear;
        st.write_reg(5'h00, 16'h2800);
        settle();
        chk({14'h0, pair_transmit_tristate, mac_rx_dv}, 16'h2);
        chk({15'h0, n_clear != n}, 16'h1);
        chk_reg(5'h00, 16'h2800);
        st.write_reg(5'h00, 16'h8000);
        n = 0;
        @(posedge sys_clk);
        chk({15'h0, soft_reset_active}, 16'h1);
        while (mgmt_busy === 1'b1 && n < 1000) begin
            n++;
            @(posedge sys_clk);
        end
        chk({15'h0, n == SR_CYC + 1}, 16'h1);
        chk_reg(5'h00, 16'h3000);
        chk({15'h0, line_tx_en}, 16'h1);
        mac_tx_en <= 1'b0;
        phy_address_strap <= 5'h00;
        rst_n <= 1'b0;
        settle();
        rst_n <= 1'b1;
        chk_reg(5'h00, 16'h3400);
        chk({15'h0, mac_out_oe}, 16'h0);
        complete_run();
    end
endmodule // pbc_basic_control_test
bind pbc_basic_control pbc_basic_control_asserts chk_i (.sys_clk, .rst_n,
    .mgmt_wr, .mgmt_addr, .mgmt_wdata, .mgmt_busy, .phy_address_strap,
    .hardware_software_select_pin, .rate_select_pin,
    .negotiation_select_pin, .duplex_select_pin, .neg_enable, .neg_restart,
    .speed_100, .full_duplex, .mac_tx_en, .mac_rx_dv, .mac_crs, .mac_col,
    .mac_out_oe, .pair_transmit_tristate);
`default_nettype wire
